// >>> hw/adc_device_end.sv
`timescale 1ns/1ps
// Notes on behaviour
// - pulsed command: result after 1624 clocks
// - held command: each conversion after the first 1622 clocks, the first 1624
// - conversion starts within two clocks plus 200ns
// - command rise latches both channel selects
// - host holds range 82 clocks before ready
// - ready low means result available
// - 16 or 20 bit word, MSB first
// - mode pin high device clocks, low host
// - MSB within 3 of ready, 3 of select
// - shift clock one clock after MSB, 1/1
// - device mode: float data on next rise
// - host shift clock at most 2.5 MHz
// - host mode: float data on falling edge
// - select high: finish bit, then float
// - ignore select during two ready-high clocks
// - host waits guard time before first rise
// - data on falling edges, rise arms shifter
// - unipolar clamps to all ones or zeros
// - bipolar clamps to all ones or zeros
// - sleep exit reapplies power-on reset
// - wake interval starts after reset ends
// - 1800 clock wake; commands held till end
// - cal pulse with command high calibrates
module adc_device_end #(
   parameter int unsigned WORD_BITS = adc_port_pkg::DEFAULT_WORD_BITS
) (
   input  wire logic                 clk,
   input  wire logic                 resetn,
   adc_link_if.device                link,
   input  wire logic [WORD_BITS-1:0] sample_code,
   input  wire logic                 over_range,
   input  wire logic                 under_range,
   input  wire logic                 sleep_req,
   output logic [1:0]                begin_sample_cmd_channel,
   output logic                      cal_busy
);
   typedef enum logic [2:0] {
      S_WAKE = 3'b000, S_IDLE = 3'b001, S_CAL = 3'b010,
      S_BEGIN_SAMPLE_CMD = 3'b011, S_SLEEP = 3'b100
   } begin_sample_cmd_state_e;
   typedef enum logic [1:0] {
      P_IDLE = 2'b00, P_LEAD = 2'b01, P_HIGH = 2'b10, P_LOW = 2'b11
   } port_state_e;

   // ---------------------------------------------------------------
   // input synchronisers
   // ---------------------------------------------------------------
   logic [1:0] begin_sample_cmd_s, cal_s, cs_s, mode_s, sclk_s;
   logic       begin_sample_cmd_d, sclk_d;
   // channel pins ride the same two stages as the command, so the
   // latch on a command rise sees both taken on the same edge
   logic [3:0] chan_s;
   always_ff @(posedge clk) begin
      begin_sample_cmd_s <= {begin_sample_cmd_s[0], link.begin_sample_cmd};
      cal_s  <= {cal_s[0], link.cal_cmd};
      cs_s   <= {cs_s[0], link.port_select_n};
      mode_s <= {mode_s[0], link.port_mode_sleep_pin};
      sclk_s <= {sclk_s[0], link.shift_clk};
      chan_s <= {chan_s[1:0], link.channel_sel1, link.channel_sel0};
      begin_sample_cmd_d <= begin_sample_cmd_s[1];
      sclk_d <= sclk_s[1];
   end
   wire begin_sample_cmd_rise  = begin_sample_cmd_s[1] & ~begin_sample_cmd_d;
   wire sclk_rise  = sclk_s[1] & ~sclk_d;
   wire sclk_fall  = ~sclk_s[1] & sclk_d;
   wire dev_mode   = mode_s[1];
   wire cs_active  = ~cs_s[1];

   // ---------------------------------------------------------------
   // conversion sequencer
   // ---------------------------------------------------------------
   begin_sample_cmd_state_e          state;
   logic [11:0]          count;
   logic                 cmd_pending, cal_pending, held_run;
   logic [1:0]           ready_hold;
   logic [WORD_BITS-1:0] result, shreg;
   logic                 ready_n;
   wire cal_req  = cal_s[1] & begin_sample_cmd_s[1];
   wire [11:0] begin_sample_cmd_len = held_run ? 12'(adc_port_pkg::BEGIN_SAMPLE_CMD_HELD_CYCLES)
                                  : 12'(adc_port_pkg::BEGIN_SAMPLE_CMD_PULSED_CYCLES);
   wire begin_sample_cmd_done = (state == S_BEGIN_SAMPLE_CMD) && (count == begin_sample_cmd_len - 12'h001);
   // clamp at the ends of the span, either range
   wire [WORD_BITS-1:0] clamped =
      over_range  ? {WORD_BITS{1'b1}} :
      under_range ? {WORD_BITS{1'b0}} : sample_code;

   always_ff @(posedge clk) begin
      if (!resetn || sleep_req) begin
         state       <= S_WAKE;
         count       <= 12'h000;
         cmd_pending <= 1'b0;
         cal_pending <= 1'b0;
         held_run    <= 1'b0;
         begin_sample_cmd_channel <= 2'h0;
         result      <= '0;
         cal_busy    <= 1'b0;
      end else begin
         if (begin_sample_cmd_rise) begin
            begin_sample_cmd_channel <= chan_s[3:2];
            cmd_pending  <= 1'b1;
         end
         if (cal_req) cal_pending <= 1'b1;
         count <= count + 12'h001;
         case (state)
            S_WAKE: if (count == 12'(adc_port_pkg::WAKE_CYCLES - 1)) begin
               state <= S_IDLE;
               count <= 12'h000;
            end
            S_IDLE: begin
               count <= 12'h000;
               if (cal_pending || cal_req) begin
                  state <= S_CAL;
                  cal_pending <= 1'b0;
                  cmd_pending <= 1'b0;
                  cal_busy <= 1'b1;
               end else if (cmd_pending || begin_sample_cmd_rise) begin
                  state <= S_BEGIN_SAMPLE_CMD;
                  cmd_pending <= 1'b0;
                  held_run <= 1'b0;
               end
            end
            S_CAL: if (count == 12'(adc_port_pkg::CAL_CYCLES - 1)) begin
               cal_busy <= 1'b0;
               count <= 12'h000;
               cmd_pending <= 1'b0;
               state <= begin_sample_cmd_s[1] ? S_BEGIN_SAMPLE_CMD : S_IDLE;
            end
            S_BEGIN_SAMPLE_CMD: if (begin_sample_cmd_done) begin
               result <= clamped;
               count <= 12'h000;
               held_run <= begin_sample_cmd_s[1] & ~cmd_pending;
               state <= (begin_sample_cmd_s[1] && !cmd_pending) ? S_BEGIN_SAMPLE_CMD : S_IDLE;
            end
            default: state <= S_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // serial port
   // ---------------------------------------------------------------
   port_state_e pstate;
   logic [4:0]  bits_left;
   logic        armed, so, so_oe, sck, sck_oe, stop_req;
   wire update_now = begin_sample_cmd_done;
   wire start_ok = cs_active && !ready_n && ready_hold == 2'h0;

   always_ff @(posedge clk) begin
      if (!resetn || sleep_req) begin
         pstate <= P_IDLE; ready_n <= 1'b1; ready_hold <= 2'h0;
         bits_left <= 5'h00; armed <= 1'b0; so <= 1'b0;
         so_oe <= 1'b0; sck <= 1'b0; sck_oe <= 1'b0;
         shreg <= '0; stop_req <= 1'b0;
      end else begin
         if (ready_hold != 2'h0) ready_hold <= ready_hold - 2'h1;
         if (update_now) begin
            ready_n <= 1'b0;
            shreg <= clamped;
            ready_hold <= 2'h0;
         // raised three counts early so ready stands high two full clocks
         end else if (state == S_BEGIN_SAMPLE_CMD && count == begin_sample_cmd_len - 12'h003
                      && ready_n == 1'b0 && pstate == P_IDLE) begin
            ready_n <= 1'b1;
            ready_hold <= 2'(adc_port_pkg::READY_HIGH_CYCLES);
         end
         if (!cs_active && pstate != P_IDLE) stop_req <= 1'b1;
         case (pstate)
            P_IDLE: begin
               stop_req <= 1'b0;
               armed <= 1'b0;
               if (start_ok && !update_now) begin
                  so <= shreg[WORD_BITS-1];
                  so_oe <= 1'b1;
                  bits_left <= 5'(WORD_BITS - 1);
                  sck_oe <= dev_mode;
                  pstate <= dev_mode ? P_LEAD : P_LOW;
               end
            end
            P_LEAD: begin
               sck <= 1'b1;
               pstate <= P_LOW;
            end
            P_HIGH: begin
               sck <= 1'b1;
               pstate <= P_LOW;
               if (bits_left == 5'h1F || stop_req) begin
                  so_oe <= 1'b0; sck_oe <= 1'b0; sck <= 1'b0;
                  pstate <= P_IDLE;
                  if (bits_left == 5'h1F) begin
                     ready_n <= 1'b1;
                     ready_hold <= 2'(adc_port_pkg::READY_HIGH_CYCLES);
                  end
               end
            end
            P_LOW: if (dev_mode) begin
               sck <= 1'b0;
               shreg <= {shreg[WORD_BITS-2:0], 1'b0};
               so <= shreg[WORD_BITS-2];
               bits_left <= bits_left - 5'h01;
               pstate <= P_HIGH;
            end else begin
               if (sclk_rise) armed <= 1'b1;
               if (sclk_fall && armed) begin
                  if (bits_left == 5'h00 || stop_req) begin
                     so_oe <= 1'b0;
                     pstate <= P_IDLE;
                     if (bits_left == 5'h00) begin
                        ready_n <= 1'b1;
                        ready_hold <=
                           2'(adc_port_pkg::READY_HIGH_CYCLES);
                     end
                  end else begin
                     shreg <= {shreg[WORD_BITS-2:0], 1'b0};
                     so <= shreg[WORD_BITS-2];
                     bits_left <= bits_left - 5'h01;
                  end
               end
            end
            default: pstate <= P_IDLE;
         endcase
      end
   end

   assign link.word_ready_n     = ready_n;
   assign link.serial_out       = so;
   assign link.serial_out_oe    = so_oe;
   assign link.shift_clk_dev    = sck;
   assign link.shift_clk_dev_oe = sck_oe;
endmodule

// >>> hw/adc_host_end.sv
`timescale 1ns/1ps
module adc_host_end #(
   parameter int unsigned WORD_BITS = adc_port_pkg::DEFAULT_WORD_BITS
) (
   input  wire logic        clk,
   input  wire logic        resetn,
   adc_link_if.host         link,
   input  wire logic [3:0]  addr,
   input  wire logic [31:0] wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [31:0]      rdata
);
   typedef enum logic [1:0] {
      H_IDLE = 2'b00, H_WAIT = 2'b01, H_HIGH = 2'b10, H_LOW = 2'b11
   } host_state_e;

   // ---------------------------------------------------------------
   // synchronisers
   // ---------------------------------------------------------------
   logic [1:0] rdy_s, dat_s, sck_s;
   logic       sck_d;
   always_ff @(posedge clk) begin
      rdy_s <= {rdy_s[0], link.word_ready_n};
      dat_s <= {dat_s[0], link.serial_line};
      sck_s <= {sck_s[0], link.shift_clk};
      sck_d <= sck_s[1];
   end
   wire sck_rise = sck_s[1] & ~sck_d;

   // ---------------------------------------------------------------
   // control register and reader
   // ---------------------------------------------------------------
   logic [6:0]           ctrl;
   host_state_e          hs;
   logic [7:0]           tcnt;
   logic [4:0]           nbits;
   logic [WORD_BITS-1:0] word;
   logic                 busy, done, sck, sck_oe, cs_n;
   wire host_mode = ~ctrl[adc_port_pkg::CTRL_MODE];
   wire rd_go = wr && addr == adc_port_pkg::REG_CTRL &&
                wdata[adc_port_pkg::CTRL_READ] && !busy;
   // guard time before the first rise, then high phases of 9 clocks and low phases of 8
   wire tdone = (tcnt == 8'h00);

   always_ff @(posedge clk) begin
      if (!resetn) begin
         ctrl <= 7'h40; hs <= H_IDLE; tcnt <= 8'h00; nbits <= 5'h00;
         word <= '0; busy <= 1'b0; done <= 1'b0; sck <= 1'b0;
         sck_oe <= 1'b0; cs_n <= 1'b1; rdata <= 32'h0000_0000;
      end else begin
         if (wr && addr == adc_port_pkg::REG_CTRL)
            ctrl <= {wdata[6], 1'b0, wdata[4:0]};
         rdata <= (addr == adc_port_pkg::REG_CTRL)   ? {25'h0, ctrl} :
                  (addr == adc_port_pkg::REG_STATUS) ?
                     {29'h0, done, busy, ~rdy_s[1]} :
                  (addr == adc_port_pkg::REG_DATA)   ?
                     32'(word) : 32'h0000_0000;
         if (rd && addr == adc_port_pkg::REG_DATA) done <= 1'b0;
         if (tcnt != 8'h00) tcnt <= tcnt - 8'h01;
         case (hs)
            H_IDLE: if (rd_go) begin
               busy <= 1'b1; cs_n <= 1'b0; nbits <= 5'h00;
               tcnt <= 8'(adc_port_pkg::CS_GUARD_CYCLES + 3); // wait
               hs <= H_WAIT;
            end
            H_WAIT: if (!host_mode) begin
               if (sck_rise) begin                       // device clock
                  word <= {word[WORD_BITS-2:0], dat_s[1]};
                  nbits <= nbits + 5'h01;
                  if (nbits == 5'(WORD_BITS - 1)) hs <= H_LOW;
               end
            end else if (tdone && !rdy_s[1]) begin
               sck_oe <= 1'b1; sck <= 1'b1;              // arming rise
               tcnt <= 8'(adc_port_pkg::SCLK_HALF_CYCLES);
               hs <= H_HIGH;
            end
            H_HIGH: if (tdone) begin
               sck <= 1'b0;
               tcnt <= 8'(adc_port_pkg::SCLK_HALF_CYCLES);
               hs <= (nbits == 5'(WORD_BITS)) ? H_LOW : H_HIGH;
               if (nbits == 5'(WORD_BITS)) tcnt <= 8'h00;
            end else if (tcnt == 8'h01 && sck) begin
               word <= {word[WORD_BITS-2:0], dat_s[1]};
               nbits <= nbits + 5'h01;
            end else if (tcnt == 8'h01 && !sck) begin
               sck <= 1'b1;
               tcnt <= 8'(adc_port_pkg::SCLK_HALF_CYCLES);
            end
            H_LOW: begin
               sck_oe <= 1'b0; sck <= 1'b0; cs_n <= 1'b1;
               busy <= 1'b0; done <= 1'b1; hs <= H_IDLE;
            end
            default: hs <= H_IDLE;
         endcase
      end
   end

   assign link.begin_sample_cmd    = ctrl[adc_port_pkg::CTRL_BEGIN_SAMPLE_CMD];
   assign link.cal_cmd             = ctrl[adc_port_pkg::CTRL_CAL];
   assign link.range_select        = ctrl[adc_port_pkg::CTRL_RANGE];
   assign link.channel_sel0        = ctrl[adc_port_pkg::CTRL_CH0];
   assign link.channel_sel1        = ctrl[adc_port_pkg::CTRL_CH1];
   assign link.port_mode_sleep_pin = ctrl[adc_port_pkg::CTRL_MODE];
   assign link.port_select_n       = cs_n;
   assign link.shift_clk_host      = sck;
   assign link.shift_clk_host_oe   = sck_oe;
endmodule

// >>> hw/adc_link_if.sv
`timescale 1ns/1ps
interface adc_link_if;
   logic begin_sample_cmd;
   logic cal_cmd;
   logic channel_sel0;
   logic channel_sel1;
   logic range_select;
   logic port_select_n;
   logic port_mode_sleep_pin;
   logic word_ready_n;
   logic serial_out;
   logic serial_out_oe;
   logic shift_clk_dev;
   logic shift_clk_dev_oe;
   logic shift_clk_host;
   logic shift_clk_host_oe;
   wire  shift_clk = shift_clk_dev_oe ? shift_clk_dev :
                     shift_clk_host_oe ? shift_clk_host : 1'b0;
   wire  serial_line = serial_out_oe ? serial_out : 1'b1;

   modport device (
      input  begin_sample_cmd, cal_cmd, channel_sel0, channel_sel1,
      input  range_select, port_select_n, port_mode_sleep_pin,
      input  shift_clk,
      output word_ready_n, serial_out, serial_out_oe,
      output shift_clk_dev, shift_clk_dev_oe
   );
   modport host (
      output begin_sample_cmd, cal_cmd, channel_sel0, channel_sel1,
      output range_select, port_select_n, port_mode_sleep_pin,
      output shift_clk_host, shift_clk_host_oe,
      input  word_ready_n, serial_line, shift_clk
   );
endinterface

// >>> hw/adc_port_pkg.sv
package adc_port_pkg;
   // ---------------------------------------------------------------
   // conversion timing, in master clock periods
   // ---------------------------------------------------------------
   localparam int unsigned BEGIN_SAMPLE_CMD_PULSED_CYCLES = 1624;
   localparam int unsigned BEGIN_SAMPLE_CMD_HELD_CYCLES   = 1622;
   localparam int unsigned CAL_CYCLES         = 3246;
   localparam int unsigned WAKE_CYCLES        = 1800;
   localparam int unsigned READY_HIGH_CYCLES  = 2;
   localparam int unsigned RANGE_SETUP_CYCLES = 82;
   // ---------------------------------------------------------------
   // host side figures
   // ---------------------------------------------------------------
   localparam int unsigned CLK_NS             = 25;
   localparam int unsigned CS_GUARD_NS        = 200;
   localparam int unsigned CS_GUARD_CYCLES    =
      2 + (CS_GUARD_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned SCLK_HALF_CYCLES   = 8;
   localparam int unsigned DEFAULT_WORD_BITS  = 20;
   // ---------------------------------------------------------------
   // host register map (word offsets)
   // ---------------------------------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h1;
   localparam logic [3:0] REG_DATA   = 4'h2;
   localparam int unsigned CTRL_BEGIN_SAMPLE_CMD  = 0;
   localparam int unsigned CTRL_CAL   = 1;
   localparam int unsigned CTRL_RANGE = 2;
   localparam int unsigned CTRL_CH0   = 3;
   localparam int unsigned CTRL_CH1   = 4;
   localparam int unsigned CTRL_READ  = 5;
   localparam int unsigned CTRL_MODE  = 6;
endpackage

// >>> testbench/adc_conversion_serial_port_tb.sv
`timescale 1ns/1ps
module adc_conversion_serial_port_tb;
   localparam int W     = adc_port_pkg::DEFAULT_WORD_BITS;
   localparam int G     = adc_port_pkg::CS_GUARD_CYCLES;
   localparam int LIMIT = 40000;
   logic         clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0;
   logic [3:0]   addr = 4'h0;
   logic [31:0]  wdata = 32'h0, rdata, last_rd;
   logic [W-1:0] sample_code = '0, wire_w;
   logic         over_range = 1'b0, under_range = 1'b0, sleep_req = 1'b0;
   logic [1:0]   begin_sample_cmd_channel;
   logic         cal_busy, rd_seen, sclk_q;
   logic [63:0]  exp_q[$], pair;
   logic [W-1:0] wire_q[$];
   int           error_cnt = 0, check_count = 0, cycles = 0, wire_n = 0;
   int           seed = 32'hE209, t0;
   adc_link_if link ();
   adc_device_end #(.WORD_BITS(W)) u_adc_device_end (.clk(clk),
      .resetn(resetn), .link(link), .sample_code(sample_code),
      .over_range(over_range), .under_range(under_range),
      .sleep_req(sleep_req), .begin_sample_cmd_channel(begin_sample_cmd_channel),
      .cal_busy(cal_busy));
   adc_host_end #(.WORD_BITS(W)) u_adc_host_end (.clk(clk),
      .resetn(resetn), .link(link), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata));
   adc_link_properties #(.WORD_BITS(W)) u_adc_link_properties (.clk(clk),
      .resetn(resetn), .begin_sample_cmd(link.begin_sample_cmd),
      .port_select_n(link.port_select_n),
      .port_mode_sleep_pin(link.port_mode_sleep_pin),
      .word_ready_n(link.word_ready_n), .serial_out(link.serial_out),
      .serial_out_oe(link.serial_out_oe),
      .shift_clk_dev(link.shift_clk_dev),
      .shift_clk_dev_oe(link.shift_clk_dev_oe),
      .shift_clk_host(link.shift_clk_host),
      .shift_clk_host_oe(link.shift_clk_host_oe),
      .shift_clk(link.shift_clk));
   always #12.5 clk = ~clk;
   // ------------------------------------------------------------
   // checking and bus tasks
   // ------------------------------------------------------------
   task automatic report(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
      report(got, exp);
   endtask
   task automatic cmp_wire(input logic [W-1:0] got, input logic [W-1:0] exp);
      report(32'(got), 32'(exp));
   endtask
   task automatic give_verdict;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // ctrl layout: mode, read, ch1, ch0, range, cal, begin_sample_cmd
   function automatic logic [31:0] ctl(input logic cv, input logic cl,
      input logic rg, input logic [1:0] ch, input logic rb, input logic md);
      return 32'({md, rb, ch, rg, cl, cv});
   endfunction
   task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic bus_rd(input logic [3:0] a, input logic [63:0] note);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      exp_q.push_back(note);
      @(posedge clk);
      rd <= 1'b0;
   endtask
   task automatic wait_lvl(input logic v);
      int k;
      k = 0;
      while (link.word_ready_n !== v && k < 8000) begin
         @(posedge clk);
         k++;
      end
   endtask
   // status polls carry an empty mask, so they are not compared
   task automatic wait_done;
      int k;
      k = 0;
      last_rd = 32'h0;
      while (last_rd[2] !== 1'b1 && k < 1000) begin
         bus_rd(adc_port_pkg::REG_STATUS, 64'h0);
         repeat (2) @(posedge clk);
         k++;
      end
   endtask
   // one pulsed conversion and read; the channel bits are turned
   // round after the command rise to catch a late latch
   task automatic do_begin_sample_cmd(input int i);
      logic [W-1:0] code, expv;
      logic [1:0]   ch;
      logic         md;
      code = W'($random(seed));
      ch   = i[1:0];
      md   = (i < 6);
      expv = (i % 4 == 1) ? '1 : (i % 4 == 2) ? '0 : code;
      sample_code <= code;
      over_range  <= (i % 4 == 1);
      under_range <= (i % 4 == 2);
      bus_wr(adc_port_pkg::REG_CTRL, ctl(1'b1, 1'b0, i[2], ch, 1'b0, md));
      t0 = cycles;
      repeat (4) @(posedge clk);
      bus_wr(adc_port_pkg::REG_CTRL, ctl(1'b0, 1'b0, i[2], ~ch, 1'b0, md));
      wait_lvl(1'b0);
      cmp_reg(32'(cycles - t0 >= 1624 && cycles - t0 <= 1628 + G), 32'h1);
      cmp_reg(32'(begin_sample_cmd_channel), 32'(ch));
      wire_q.push_back(expv);
      bus_wr(adc_port_pkg::REG_CTRL, ctl(1'b0, 1'b0, i[2], ~ch, 1'b1, md));
      wait_done();
      cmp_reg(32'(link.word_ready_n), 32'h1);
      bus_rd(adc_port_pkg::REG_DATA, {(32'h1 << W) - 32'h1, 32'(expv)});
   endtask
   // ------------------------------------------------------------
   // result watcher and hang limit
   // ------------------------------------------------------------
   always @(posedge clk) begin
      cycles  <= cycles + 1;
      rd_seen <= rd;
      sclk_q  <= link.shift_clk;
      if (cycles == LIMIT) begin
         error_cnt++;
         give_verdict();
      end
      if (rd_seen) begin
         pair    = exp_q.pop_front();
         last_rd = rdata;
         if (pair[63:32] != 32'h0)
            cmp_reg(rdata & pair[63:32], pair[31:0]);
      end
      if (link.port_select_n) begin
         wire_n <= 0;
      end else if (link.shift_clk && !sclk_q && wire_n < W) begin
         wire_w <= {wire_w[W-2:0], link.serial_line};
         wire_n <= wire_n + 1;
         if (wire_n == W - 1)
            cmp_wire({wire_w[W-2:0], link.serial_line}, wire_q.pop_front());
      end
   end
   // main sequence: wake with held calibration, conversions, sleep
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      t0 = cycles;
      bus_wr(adc_port_pkg::REG_CTRL, ctl(1'b1, 1'b0, 1'b0, 2'h1, 1'b0, 1'b1));
      bus_wr(adc_port_pkg::REG_CTRL, ctl(1'b1, 1'b1, 1'b0, 2'h1, 1'b0, 1'b1));
      repeat (4) @(posedge clk);
      bus_wr(adc_port_pkg::REG_CTRL, ctl(1'b1, 1'b0, 1'b0, 2'h1, 1'b0, 1'b1));
      repeat (1690) @(posedge clk);
      cmp_reg(32'(cal_busy), 32'h0);
      while (cal_busy !== 1'b1 && cycles - t0 < 2000)
         @(posedge clk);
      cmp_reg(32'(cycles - t0 >= 1800 && cycles - t0 <= 1804 + G), 32'h1);
      wait_lvl(1'b0);
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      bus_wr(adc_port_pkg::REG_CTRL, ctl(1'b0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1));
      // the held command has begun one more conversion already:
      // take its word out so every loop pass starts with ready high
      wait_lvl(1'b1);
      wait_lvl(1'b0);
      wire_q.push_back('0);
      bus_wr(adc_port_pkg::REG_CTRL, ctl(1'b0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b1));
      wait_done();
      bus_rd(adc_port_pkg::REG_DATA, {(32'h1 << W) - 32'h1, 32'h0});
      for (int i = 0; i < 8; i++)
         do_begin_sample_cmd(i);
      sleep_req <= 1'b1;
      repeat (10) @(posedge clk);
      sleep_req <= 1'b0;
      t0 = cycles;
      bus_wr(adc_port_pkg::REG_CTRL, ctl(1'b1, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1));
      repeat (4) @(posedge clk);
      bus_wr(adc_port_pkg::REG_CTRL, ctl(1'b0, 1'b0, 1'b0, 2'h2, 1'b0, 1'b1));
      wait_lvl(1'b0);
      cmp_reg(32'(cycles - t0 >= 3424 && cycles - t0 <= 3430 + G), 32'h1);
      give_verdict();
   end
endmodule

// >>> testbench/adc_link_properties.sv
`timescale 1ns/1ps
module adc_link_properties #(
   parameter int unsigned WORD_BITS = 20
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic begin_sample_cmd,
   input wire logic port_select_n,
   input wire logic port_mode_sleep_pin,
   input wire logic word_ready_n,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   input wire logic shift_clk_dev,
   input wire logic shift_clk_dev_oe,
   input wire logic shift_clk_host,
   input wire logic shift_clk_host_oe,
   input wire logic shift_clk
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // ------------------------------------------------------------
   // helper counters
   // ------------------------------------------------------------
   logic [11:0] held_cnt;
   logic        held_ok;
   logic [5:0]  rise_cnt;
   // arms only at a result that lands while the command stays held
   always_ff @(posedge clk) begin
      if (!resetn || !begin_sample_cmd) begin
         held_ok  <= 1'b0;
         held_cnt <= 12'h000;
      end else if ($fell(word_ready_n)) begin
         held_ok  <= 1'b1;
         held_cnt <= 12'h001;
      end else begin
         held_cnt <= held_cnt + 12'h001;
      end
   end
   // rises of the device clock within one frame
   always_ff @(posedge clk) begin
      if (!resetn || !serial_out_oe) begin
         rise_cnt <= 6'h00;
      end else if ($rose(shift_clk_dev)) begin
         rise_cnt <= rise_cnt + 6'h01;
      end
   end
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   sequence first_rise;
      !shift_clk_dev ##1 shift_clk_dev;
   endsequence
   sequence host_guard;
      !shift_clk_host [*8] ##1 !shift_clk_host [*2];
   endsequence
   chk_msb_on_select:
      assert property (port_mode_sleep_pin && !word_ready_n &&
         $fell(port_select_n) |-> ##[1:4] serial_out_oe)
      else $error("msb late after select");
   chk_sclk_after_msb:
      assert property ($rose(serial_out_oe) && port_mode_sleep_pin |->
         first_rise) else $error("shift clock not one clock after msb");
   chk_ready_high_two:
      assert property ($rose(word_ready_n) |=> word_ready_n)
      else $error("ready high for less than two clocks");
   chk_float_deselect:
      assert property ($rose(port_select_n) && port_mode_sleep_pin |->
         ##[0:4] !serial_out_oe && !shift_clk_dev_oe)
      else $error("outputs still driven after deselect");
   chk_dev_clk_idle:
      assert property (!port_mode_sleep_pin [*3] |-> !shift_clk_dev_oe)
      else $error("device drives clock in host mode");
   chk_host_clk_idle:
      assert property (port_mode_sleep_pin [*3] |-> !shift_clk_host_oe)
      else $error("host drives clock in device mode");
   chk_data_low_phase:
      assert property (serial_out_oe && $past(serial_out_oe) &&
         $changed(serial_out) |-> !shift_clk)
      else $error("data changed while shift clock high");
   chk_held_period:
      assert property ($fell(word_ready_n) && held_ok |->
         held_cnt == 12'h656) else $error("held period not 1622");
   chk_float_last_rise:
      assert property ($fell(serial_out_oe) && port_mode_sleep_pin &&
         !port_select_n |-> rise_cnt == 6'(WORD_BITS) ||
         (rise_cnt == 6'(WORD_BITS - 1) && shift_clk_dev))
      else $error("data floated at wrong rise");
   chk_host_guard:
      assert property ($fell(port_select_n) && !port_mode_sleep_pin |->
         host_guard) else $error("host clock rose inside guard");
   // eight clocks a phase keeps the host clock at or under 2.5 MHz
   sequence sclk_high_phase;
      shift_clk_host [*8];
   endsequence
   sequence sclk_low_phase;
      !shift_clk_host [*8];
   endsequence
   chk_host_high_width:
      assert property ($rose(shift_clk_host) |-> sclk_high_phase)
      else $error("host shift clock high phase too short");
   chk_host_low_width:
      assert property ($fell(shift_clk_host) |-> sclk_low_phase)
      else $error("host shift clock low phase too short");
endmodule
